/* logic/sac_defines.svh */
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH
`define SAC_ADDR_CHSEL    8'hBB
`define SAC_ADDR_CFG      8'hBC
`define SAC_ADDR_RESULT   8'hBE
`define SAC_ADDR_LOWER    8'hC4
`define SAC_ADDR_UPPER    8'hC6
`define SAC_ADDR_CTRL     8'hE8
`define SAC_RST_CHSEL     8'h00
`define SAC_RST_CFG       8'hF8
`define SAC_RST_RESULT    8'h00
`define SAC_RST_LOWER     8'hFF
`define SAC_RST_UPPER     8'h00
`define SAC_RST_CTRL      8'h00
`define SAC_CFG_WMASK     8'hFB
`define SAC_BIT_EN        7
`define SAC_BIT_TM        6
`define SAC_BIT_DONE      5
`define SAC_BIT_BUSY      4
`define SAC_BIT_WIN       3
`define SAC_TRACK_CLKS    3'h3
`define SAC_CONV_CLKS     4'h8
`endif

/* logic/sac_pkg.sv */
package sac_pkg;
  typedef enum logic [1:0] {
    SAC_IDLE,
    SAC_TRACK,
    SAC_CONV
  } sac_state_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sac_bus_s;

  typedef struct packed {
    logic       tmr0_ovf;
    logic       tmr1_ovf;
    logic       tmr2_lo_ovf;
    logic       tmr2_hi_ovf;
    logic       tmr2_16bit;
  } sac_timer_s;
endpackage

/* logic/sac_sync.sv */
`timescale 1ns/1ps
module sac_sync
  import sac_pkg::*;
(
  // Clock and reset.
  input  wire logic clock,
  input  wire logic rst_n,
  // Asynchronous level in, synchronised level out.
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule

/* logic/sac_core.sv */
`timescale 1ns/1ps
`include "sac_defines.svh"
module sac_core
  import sac_pkg::*;
(
  // Clock and reset.
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Register port.
  input  wire sac_bus_s   bus,
  output logic [7:0]      rdata,
  // Start sources.
  input  wire sac_timer_s tmr,
  input  wire logic       ext_conv_start,
  // Analog front end.
  input  wire logic       cmp_in,
  output logic [3:0]      positive_input_sel,
  output logic [2:0]      negative_pin_sel,
  output logic            negative_is_gnd,
  output logic            differential_mode,
  output logic [1:0]      gain_select,
  output logic            analog_enable,
  output logic            track_active,
  output logic [7:0]      sar_trial,
  output logic            sar_clk_en,
  // Status.
  output logic            conv_busy,
  output logic            conv_done_irq
);
  logic [7:0] chsel_ff;
  logic [7:0] cfg_ff;
  logic [7:0] result_ff;
  logic [7:0] lower_ff;
  logic [7:0] upper_ff;
  logic [7:0] ctrl_ff;
  logic [4:0] div_cnt_ff;
  logic [3:0] step_ff;
  logic [7:0] sar_ff;
  logic       busy_d_ff;
  logic       ext_d_ff;
  logic       ext_sync;
  logic       ext_rise;
  logic       sw_start;
  logic       trig;
  logic       tmr2_ovf;
  logic       win_hit;
  logic       done_evt;
  logic       wr_ctrl;
  logic       tm_lp;
  logic       src_ext;
  logic       sar_tick;
  logic [7:0] res_nxt;
  sac_state_e state_ff;
  sac_state_e nxt_state;

  sac_sync u_ext_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in (ext_conv_start),
    .sync_out (ext_sync)
  );

  assign negative_is_gnd    = chsel_ff[7];
  assign negative_pin_sel   = chsel_ff[6:4];
  assign differential_mode  = ~chsel_ff[7];
  assign positive_input_sel = chsel_ff[3:0];
  assign gain_select        = cfg_ff[1:0];
  assign analog_enable      = ctrl_ff[`SAC_BIT_EN];
  assign sar_trial          = sar_ff;
  assign conv_busy          = (state_ff != SAC_IDLE);
  assign tm_lp              = ctrl_ff[`SAC_BIT_TM];
  assign src_ext            = ctrl_ff[2];

  // SAR clock enable: one pulse every divider+1 system clocks.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      div_cnt_ff <= 5'h00;
    else if (div_cnt_ff >= cfg_ff[7:3])
      div_cnt_ff <= 5'h00;
    else
      div_cnt_ff <= div_cnt_ff + 5'h01;
  end
  assign sar_tick   = (div_cnt_ff >= cfg_ff[7:3]);
  assign sar_clk_en = sar_tick;

  assign wr_ctrl  = bus.wr && (bus.addr == `SAC_ADDR_CTRL);
  assign sw_start = wr_ctrl && bus.wdata[`SAC_BIT_BUSY]
                    && (bus.wdata[2:0] == 3'h0);
  assign tmr2_ovf = tmr.tmr2_16bit ? tmr.tmr2_hi_ovf : tmr.tmr2_lo_ovf;
  assign ext_rise = ext_sync && !ext_d_ff;

  always_comb
  begin
    case (ctrl_ff[2:0])
      3'h0:    trig = sw_start;
      3'h1:    trig = tmr.tmr0_ovf;
      3'h2:    trig = tmr2_ovf;
      3'h3:    trig = tmr.tmr1_ovf;
      default: trig = ext_rise;
    endcase
  end

  // Tracking: normal mode whenever enabled and idle; low-power per source.
  always_comb
  begin
    if (!ctrl_ff[`SAC_BIT_EN])
      track_active = 1'b0;
    else if (!tm_lp)
      track_active = (state_ff == SAC_IDLE);
    else if (src_ext)
      track_active = (state_ff == SAC_IDLE) && !ext_sync;
    else
      track_active = (state_ff == SAC_TRACK);
  end

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      SAC_IDLE:
        if (ctrl_ff[`SAC_BIT_EN] && trig)
          nxt_state = (tm_lp && !src_ext) ? SAC_TRACK : SAC_CONV;
      SAC_TRACK:
        if (sar_tick && step_ff == `SAC_TRACK_CLKS - 4'h1)
          nxt_state = SAC_CONV;
      SAC_CONV:
        if (sar_tick && step_ff == `SAC_CONV_CLKS - 4'h1)
          nxt_state = SAC_IDLE;
      default:
        nxt_state = SAC_IDLE;
    endcase
    if (!ctrl_ff[`SAC_BIT_EN])
      nxt_state = SAC_IDLE;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      state_ff <= SAC_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Step counter counts SAR clocks within track and conversion phases.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      step_ff <= 4'h0;
    else if (nxt_state != state_ff)
      step_ff <= 4'h0;
    else if (sar_tick && state_ff != SAC_IDLE)
      step_ff <= step_ff + 4'h1;
  end

  // Successive approximation: one bit decided per SAR clock, MSB first.
  always_comb
  begin
    res_nxt = sar_ff;
    if (!cmp_in)
      res_nxt[3'h7 - step_ff[2:0]] = 1'b0;
    if (step_ff[2:0] != 3'h7)
      res_nxt[3'h6 - step_ff[2:0]] = 1'b1;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      sar_ff <= 8'h80;
    else if (state_ff != SAC_CONV)
      sar_ff <= 8'h80;
    else if (sar_tick)
      sar_ff <= res_nxt;
  end

  assign done_evt   = busy_d_ff && (state_ff == SAC_IDLE);

  // A conversion cut short by disabling leaves busy without raising completion.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_d_ff <= 1'b0;
      ext_d_ff  <= 1'b0;
    end
    else
    begin
      busy_d_ff <= (state_ff == SAC_CONV) && ctrl_ff[`SAC_BIT_EN];
      ext_d_ff  <= ext_sync;
    end
  end

  // Window compare; signed in differential mode.
  always_comb
  begin
    logic gt_lo;
    logic lt_up;
    logic up_gt_lo;
    gt_lo    = 1'b0;
    lt_up    = 1'b0;
    up_gt_lo = 1'b0;
    if (differential_mode)
    begin
      gt_lo    = $signed(result_ff) > $signed(lower_ff);
      lt_up    = $signed(result_ff) < $signed(upper_ff);
      up_gt_lo = $signed(upper_ff) > $signed(lower_ff);
    end
    else
    begin
      gt_lo    = result_ff > lower_ff;
      lt_up    = result_ff < upper_ff;
      up_gt_lo = upper_ff > lower_ff;
    end
    win_hit = up_gt_lo ? (gt_lo && lt_up) : (gt_lo || lt_up);
  end

  // Result capture at the end of the final SAR step.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      result_ff <= `SAC_RST_RESULT;
    else if (state_ff == SAC_CONV && nxt_state == SAC_IDLE && ctrl_ff[`SAC_BIT_EN])
      result_ff <= res_nxt;
    else if (bus.wr && bus.addr == `SAC_ADDR_RESULT)
      result_ff <= bus.wdata;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chsel_ff <= `SAC_RST_CHSEL;
      cfg_ff   <= `SAC_RST_CFG;
      lower_ff <= `SAC_RST_LOWER;
      upper_ff <= `SAC_RST_UPPER;
    end
    else if (bus.wr)
    begin
      if (bus.addr == `SAC_ADDR_CHSEL)
        chsel_ff <= bus.wdata;
      if (bus.addr == `SAC_ADDR_CFG)
        cfg_ff <= bus.wdata & `SAC_CFG_WMASK;
      if (bus.addr == `SAC_ADDR_LOWER)
        lower_ff <= bus.wdata;
      if (bus.addr == `SAC_ADDR_UPPER)
        upper_ff <= bus.wdata;
    end
  end

  // Control: flags set by hardware win over a same-cycle software clear.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_ff <= `SAC_RST_CTRL;
    else
    begin
      if (wr_ctrl)
      begin
        ctrl_ff[7:6] <= bus.wdata[7:6];
        ctrl_ff[2:0] <= bus.wdata[2:0];
        ctrl_ff[`SAC_BIT_DONE] <= bus.wdata[`SAC_BIT_DONE];
        ctrl_ff[`SAC_BIT_WIN]  <= bus.wdata[`SAC_BIT_WIN];
      end
      if (done_evt)
        ctrl_ff[`SAC_BIT_DONE] <= 1'b1;
      if (done_evt && win_hit)
        ctrl_ff[`SAC_BIT_WIN] <= 1'b1;
      ctrl_ff[`SAC_BIT_BUSY] <= 1'b0;
    end
  end

  assign conv_done_irq = done_evt;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 8'h00;
    else if (bus.rd)
    begin
      case (bus.addr)
        `SAC_ADDR_CHSEL:  rdata <= chsel_ff;
        `SAC_ADDR_CFG:    rdata <= cfg_ff;
        `SAC_ADDR_RESULT: rdata <= result_ff;
        `SAC_ADDR_LOWER:  rdata <= lower_ff;
        `SAC_ADDR_UPPER:  rdata <= upper_ff;
        `SAC_ADDR_CTRL:   rdata <= {ctrl_ff[7:5], conv_busy, ctrl_ff[3:0]};
        default:          rdata <= 8'h00;
      endcase
    end
  end

  property p_cfg_bit2;
    @(posedge clock) disable iff (!rst_n) cfg_ff[2] == 1'b0;
  endproperty
  a_cfg_bit2: assert property (p_cfg_bit2) else $error("cfg bit2 set");

  property p_no_conv_off;
    @(posedge clock) disable iff (!rst_n)
      !ctrl_ff[`SAC_BIT_EN] |=> state_ff == SAC_IDLE;
  endproperty
  a_no_conv_off: assert property (p_no_conv_off) else $error("conv while off");

  property p_done_sticky;
    @(posedge clock) disable iff (!rst_n)
      ctrl_ff[`SAC_BIT_DONE] && !wr_ctrl |=> ctrl_ff[`SAC_BIT_DONE];
  endproperty
  a_done_sticky: assert property (p_done_sticky) else $error("done lost");

  property p_done_set;
    @(posedge clock) disable iff (!rst_n)
      done_evt |=> ctrl_ff[`SAC_BIT_DONE];
  endproperty
  a_done_set: assert property (p_done_set) else $error("done not set");

  property p_win_sticky;
    @(posedge clock) disable iff (!rst_n)
      ctrl_ff[`SAC_BIT_WIN] && !wr_ctrl |=> ctrl_ff[`SAC_BIT_WIN];
  endproperty
  a_win_sticky: assert property (p_win_sticky) else $error("window lost");

  property p_no_start_nonsw;
    @(posedge clock) disable iff (!rst_n)
      state_ff == SAC_IDLE && ctrl_ff[2:0] != 3'h0 && !tmr.tmr0_ovf && !tmr.tmr1_ovf
      && !tmr.tmr2_lo_ovf && !tmr.tmr2_hi_ovf && !ext_rise |=> state_ff == SAC_IDLE;
  endproperty
  a_no_start_nonsw: assert property (p_no_start_nonsw) else $error("bad start");

  property p_track_norm;
    @(posedge clock) disable iff (!rst_n)
      ctrl_ff[`SAC_BIT_EN] && !tm_lp && state_ff == SAC_IDLE |-> track_active;
  endproperty
  a_track_norm: assert property (p_track_norm) else $error("not tracking");

  property p_diff_mode;
    @(posedge clock) disable iff (!rst_n)
      differential_mode == (chsel_ff[7:4] < 4'h8);
  endproperty
  a_diff_mode: assert property (p_diff_mode) else $error("mode wrong");
endmodule

/* tb/sac_partner.sv */
`timescale 1ns/1ps
module sac_partner
  import sac_pkg::*;
(
  // Clock.
  input  wire logic       clock,
  // Towards the converter.
  output sac_timer_s      tmr,
  output logic            ext_conv_start,
  output logic            cmp_in,
  input  wire logic [7:0] sar_trial
);
  logic [7:0] level;

  // The comparator answers one when the held input is at or above the trial code.
  assign cmp_in = (level >= sar_trial);

  initial
  begin
    tmr            = '0;
    ext_conv_start = 1'b0;
    level          = 8'h00;
  end

  // Pulses one overflow for a clock: 0 timer 0, 1 timer 1, 2 timer 2 low, 3 timer 2 high.
  task automatic overflow(input int src);
    @(posedge clock);
    tmr[4 - src] <= 1'b1;
    @(posedge clock);
    tmr[4 - src] <= 1'b0;
  endtask

  task automatic mode16(input logic m);
    @(posedge clock);
    tmr.tmr2_16bit <= m;
  endtask

  // The pin is held low to track and raised to start a conversion.
  task automatic pin(input logic lvl);
    @(posedge clock);
    ext_conv_start <= lvl;
  endtask
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
module tb
  import sac_pkg::*;
;
  logic       clock, rst_n, ext_conv_start, cmp_in, negative_is_gnd, differential_mode, trk;
  logic       analog_enable, track_active, sar_clk_en, conv_busy, conv_done_irq;
  logic [7:0] rdata, sar_trial, v;
  logic [3:0] positive_input_sel;
  logic [2:0] negative_pin_sel;
  logic [1:0] gain_select;
  sac_bus_s   bus;
  sac_timer_s tmr;
  int         miscompares, total_checks, cyc;
  logic [7:0]  ra [7]   = '{8'hBB, 8'hBC, 8'hBE, 8'hC4, 8'hC6, 8'hE8, 8'hC0};
  logic [7:0]  rv [7]   = '{8'h00, 8'hF8, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};
  logic [31:0] win [5]  = '{32'h102015A8, 32'h102010A0, 32'h102020A0, 32'h201005A8, 32'h201015A0};
  logic [15:0] tsrc [4] = '{16'h0110, 16'h0301, 16'h0232, 16'h1223};

  sac_core u_dut (.clock(clock), .rst_n(rst_n), .bus(bus), .rdata(rdata), .tmr(tmr),
    .ext_conv_start(ext_conv_start), .cmp_in(cmp_in), .positive_input_sel(positive_input_sel),
    .negative_pin_sel(negative_pin_sel), .negative_is_gnd(negative_is_gnd),
    .differential_mode(differential_mode), .gain_select(gain_select),
    .analog_enable(analog_enable), .track_active(track_active), .sar_trial(sar_trial),
    .sar_clk_en(sar_clk_en), .conv_busy(conv_busy), .conv_done_irq(conv_done_irq));

  sac_partner u_part (.clock(clock), .tmr(tmr), .ext_conv_start(ext_conv_start),
    .cmp_in(cmp_in), .sar_trial(sar_trial));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= {1'b1, 1'b0, a, d};
    @(posedge clock);
    bus <= '0;
  endtask

  task automatic rc(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    bus <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clock);
    bus <= '0;
    @(negedge clock);
    chk(what, exp, rdata);
  endtask

  // Counts cycles up to the completion pulse and notes tracking seen while busy.
  task automatic wait_done(input int lim);
    cyc = 0;
    trk = 1'b0;
    while (cyc < lim && conv_done_irq !== 1'b1)
    begin
      @(negedge clock);
      cyc++;
      if (conv_busy === 1'b1 && track_active === 1'b1)
        trk = 1'b1;
    end
  endtask

  task automatic sw(input logic [7:0] ctl, input logic [7:0] lvl);
    u_part.level = lvl;
    wr(8'hE8, ctl);
    wait_done(200);
  endtask

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial
  begin
    repeat (30000) @(posedge clock);
    $display("watchdog expired");
    miscompares++;
    end_of_test();
  end

  initial
  begin
    rst_n = 1'b0;
    bus   = '0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++)
      rc("reset value", ra[i], rv[i]);
    $display("test reset values done");
    wr(8'hBC, 8'hFF);
    rc("configuration", 8'hBC, 8'hFB);
    for (int g = 0; g < 4; g++)
    begin
      wr(8'hBC, 8'h3C + 8'(g));
      rc("configuration", 8'hBC, 8'h38 + 8'(g));
      chk("gain", 8'(g), {6'h0, gain_select});
    end
    while (sar_clk_en !== 1'b1)
      @(negedge clock);
    @(negedge clock);
    v = 8'h01;
    while (sar_clk_en !== 1'b1 && v < 8'h40)
    begin
      @(negedge clock);
      v++;
    end
    chk("SAR clock period", 8'h08, v);
    $display("test configuration done");
    for (int i = 0; i < 16; i++)
    begin
      wr(8'hBB, {4'(i), 4'(i)});
      repeat (2) @(negedge clock);
      chk("positive input", 8'(i), {4'h0, positive_input_sel});
      chk("ground select", {7'h0, i[3]}, {7'h0, negative_is_gnd});
      chk("differential", {7'h0, !i[3]}, {7'h0, differential_mode});
      if (!i[3])
        chk("negative pin", 8'(i), {5'h0, negative_pin_sel});
    end
    $display("test input selection done");
    wr(8'hBB, 8'h80);
    sw(8'h10, 8'hA5);
    chk("start while disabled", 8'h01, {7'h0, cyc == 200});
    chk("enable", 8'h00, {7'h0, analog_enable});
    chk("shutdown tracking", 8'h00, {7'h0, track_active});
    wr(8'hE8, 8'h80);
    sw(8'h91, 8'hA5);
    chk("busy write with timer source", 8'h01, {7'h0, cyc == 200});
    wr(8'hE8, 8'h80);
    @(negedge clock);
    chk("idle tracking", 8'h01, {7'h0, track_active});
    sw(8'h90, 8'hA5);
    chk("conversion time", 8'h01, {7'h0, cyc >= 56 && cyc <= 76});
    chk("tracking while busy", 8'h00, {7'h0, trk});
    rc("result", 8'hBE, 8'hA5);
    rc("control", 8'hE8, 8'hA0);
    rc("control", 8'hE8, 8'hA0);
    wr(8'hE8, 8'h80);
    rc("control", 8'hE8, 8'h80);
    $display("test software start done");
    foreach (win[k])
    begin
      wr(8'hC4, win[k][31:24]);
      wr(8'hC6, win[k][23:16]);
      sw(8'h90, win[k][15:8]);
      rc("window flag", 8'hE8, win[k][7:0]);
      wr(8'hE8, 8'h80);
    end
    $display("test window done");
    foreach (tsrc[k])
    begin
      u_part.mode16(tsrc[k][12]);
      wr(8'hE8, {4'h8, tsrc[k][11:8]});
      u_part.overflow(tsrc[k][7:4]);
      wait_done(200);
      chk("other timer", 8'h01, {7'h0, cyc == 200});
      u_part.overflow(tsrc[k][3:0]);
      wait_done(200);
      chk("timer start", 8'h01, {7'h0, cyc < 200});
      wr(8'hE8, 8'h80);
    end
    $display("test timer sources done");
    for (int c = 4; c < 8; c += 3)
    begin
      wr(8'hE8, 8'h80 | 8'(c));
      u_part.pin(1'b1);
      wait_done(200);
      chk("pin start", 8'h01, {7'h0, cyc < 200});
      u_part.pin(1'b0);
      wr(8'hE8, 8'h80);
    end
    $display("test external start done");
    wr(8'hE8, 8'hC0);
    sw(8'hD0, 8'h3C);
    chk("low power time", 8'h01, {7'h0, cyc >= 80 && cyc <= 100});
    rc("result", 8'hBE, 8'h3C);
    wr(8'hE8, 8'hC4);
    repeat (6) @(negedge clock);
    chk("pin low tracking", 8'h01, {7'h0, track_active});
    u_part.pin(1'b1);
    wait_done(200);
    chk("pin rise start", 8'h01, {7'h0, cyc < 200});
    @(negedge clock);
    chk("pin high hold", 8'h00, {7'h0, track_active});
    u_part.pin(1'b0);
    wr(8'hE8, 8'h80);
    $display("test low power done");
    end_of_test();
  end
endmodule
